// ===== vic_pkg.sv
// Package of constants, types and helpers for the vectored interrupt controller
// Function
// - All peripheral requests merge into one request toward the core.
// - Eight trap sources exist and can never be masked.
// - Seven programmable priority levels can be given to the four priority_control_four sources; all other interrupt sources stay at level 4, traps at 8.
// - Primary table starts at 000004h: 8 traps then 118 source vectors.
// - Each entry holds a 24-bit routine address, fetched when servicing.
// - Every source owns one distinct table entry.
// - On equal terms the lower table position wins; vector 0 beats all.
// - Sources at the same priority level are ordered by vector position.
// - Alternate table follows primary; select bit 15 switches all vectoring.
// - Entry and return take a fixed cycle count for every source.
// - Reset bypasses the controller; execution restarts at address 000000h.
package vic_pkg;
   localparam int NTRAP = 8;
   localparam int NIRQ = 118;
   localparam int NVEC = NTRAP + NIRQ;
   localparam int IDX_W = 7;
   localparam int LVL_W = 4;
   localparam int PA_W = 24;
   localparam int CNT_W = 4;
   localparam int AXI_AW = 8;
   localparam logic [PA_W-1:0] IVT_BASE = 24'h000004;
   localparam logic [PA_W-1:0] ALTERNATE_VECTOR_TABLE_BASE = IVT_BASE + 24'(NVEC * 2);
   localparam logic [PA_W-1:0] RESET_PC = 24'h000000;
   localparam logic [LVL_W-1:0] TRAP_LVL = 4'h8;
   localparam logic [2:0] DEF_PRIO = 3'h4;
   // Interrupt source numbers of the four sources held in priority_control_four
   localparam int SRC_SI2C = 16;
   localparam int SRC_MI2C = 17;
   localparam int SRC_CN = 18;
   localparam int SRC_CMP = 19;
   // Register map
   localparam logic [AXI_AW-1:0] OFF_PRIO4 = 8'h00;
   localparam logic [AXI_AW-1:0] OFF_ICON2 = 8'h04;
   localparam logic [AXI_AW-1:0] OFF_STAT = 8'h08;
   localparam int CN_LSB = 12;
   localparam int CMP_LSB = 8;
   localparam int MI2C_LSB = 4;
   localparam int SI2C_LSB = 0;
   localparam logic [15:0] PRIO4_RST = 16'h4444;
   localparam logic [15:0] PRIO4_MASK = 16'h7777;
   localparam int ALT_BIT = 15;
   localparam logic [15:0] ICON2_RST = 16'h0000;
   localparam logic [15:0] ICON2_MASK = 16'h8000;
   localparam int STAT_IRQ_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_IDX_LSB = 8;
   localparam int STAT_LVL_LSB = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int ENTRY_NS = 40;
   localparam int RET_NS = 30;
   localparam int ENTRY_CYC = (ENTRY_NS * CLK_MHZ + 999) / 1000;
   localparam int RET_CYC = (RET_NS * CLK_MHZ + 999) / 1000;

   typedef struct packed {
      logic valid;
      logic [IDX_W-1:0] idx;
      logic [LVL_W-1:0] lvl;
   } vic_win_s;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ENTER = 4'b0010,
      ST_SVC = 4'b0100,
      ST_RET = 4'b1000
   } vic_state_e;

   function automatic logic [PA_W-1:0] vic_vec_addr(input logic alt, input logic [IDX_W-1:0] idx);
      vic_vec_addr = (alt ? ALTERNATE_VECTOR_TABLE_BASE : IVT_BASE) + {16'h0000, idx, 1'b0};
   endfunction : vic_vec_addr

   function automatic logic [15:0] vic_merge16(input logic [15:0] old, input logic [31:0] data,
                                               input logic [3:0] strb, input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (strb[0])
      begin
         v[7:0] = data[7:0];
      end
      if (strb[1])
      begin
         v[15:8] = data[15:8];
      end
      vic_merge16 = v & mask;
   endfunction : vic_merge16
endpackage : vic_pkg

// ===== vic_prio_arb.sv
// Priority arbiter: highest level wins, lower vector position breaks ties
`timescale 1ns/1ps
module vic_prio_arb (
   input wire logic [vic_pkg::NVEC-1:0] req,
   input wire logic [vic_pkg::NVEC-1:0][vic_pkg::LVL_W-1:0] lvl,
   output vic_pkg::vic_win_s win
);
   vic_pkg::vic_win_s stg [0:vic_pkg::NVEC];

   assign stg[0] = '0;
   genvar i;
   generate
      for (i = 0; i < vic_pkg::NVEC; i++)
      begin : g_stage
         // Strictly greater keeps the earlier, lower-addressed vector
         assign stg[i+1] = (req[i] && (!stg[i].valid || lvl[i] > stg[i].lvl)) ?
                           vic_pkg::vic_win_s'{valid: 1'b1, idx: 7'(i), lvl: lvl[i]} :
                           stg[i];
      end
   endgenerate
   assign win = stg[vic_pkg::NVEC];
endmodule : vic_prio_arb

// ===== vic_vec_fetch.sv
// Vector fetch: reads the routine address of one table entry
`timescale 1ns/1ps
module vic_vec_fetch (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic start,
   input wire logic alt,
   input wire logic [vic_pkg::IDX_W-1:0] idx,
   output logic vt_rd,
   output logic [vic_pkg::PA_W-1:0] vt_addr,
   input wire logic [vic_pkg::PA_W-1:0] vt_data,
   output logic [vic_pkg::PA_W-1:0] isr_addr
);
   logic rd_q_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         vt_rd <= 1'b0;
         vt_addr <= 24'h000000;
         rd_q_r <= 1'b0;
         isr_addr <= 24'h000000;
      end
      else if (ce)
      begin
         vt_rd <= start;
         rd_q_r <= vt_rd;
         if (start)
         begin
            vt_addr <= vic_pkg::vic_vec_addr(alt, idx);
         end
         if (rd_q_r)
         begin
            isr_addr <= vt_data;
         end
      end
   end
endmodule : vic_vec_fetch

// ===== vic_top.sv
// Vectored interrupt controller top with AXI4-Lite register slave
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module vic_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [vic_pkg::NTRAP-1:0] trap_req,
   input wire logic [vic_pkg::NIRQ-1:0] irq_req,
   input wire logic [vic_pkg::LVL_W-1:0] core_ipl,
   input wire logic core_ack,
   input wire logic core_ret,
   output logic core_irq,
   output logic [vic_pkg::IDX_W-1:0] core_vec_idx,
   output logic [vic_pkg::LVL_W-1:0] core_irq_lvl,
   output logic isr_valid,
   output logic [vic_pkg::PA_W-1:0] isr_addr,
   output logic boot_load,
   output logic [vic_pkg::PA_W-1:0] boot_addr,
   output logic vt_rd,
   output logic [vic_pkg::PA_W-1:0] vt_addr,
   input wire logic [vic_pkg::PA_W-1:0] vt_data,
   input wire logic [vic_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [vic_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // Registered outputs are seen one edge after their count ends
   localparam int ENTRY_D = vic_pkg::ENTRY_CYC + 1;
   localparam int RET_D = vic_pkg::RET_CYC + 1;

   logic [15:0] prio4_r;
   logic [15:0] icon2_r;
   logic aw_ok_r;
   logic [vic_pkg::AXI_AW-1:0] aw_addr_r;
   logic w_ok_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic rd_prio_r;
   vic_pkg::vic_state_e st_r;
   vic_pkg::vic_state_e st_nxt;
   logic [vic_pkg::CNT_W-1:0] cnt_r;
   logic [vic_pkg::IDX_W-1:0] act_idx_r;
   logic [vic_pkg::LVL_W-1:0] act_lvl_r;
   logic boot_pend_r;

   // Register bus decode
   wire do_wr = aw_ok_r && w_ok_r && !s_axi_bvalid;
   wire wr_prio4 = aw_addr_r == vic_pkg::OFF_PRIO4;
   wire wr_icon2 = aw_addr_r == vic_pkg::OFF_ICON2;
   wire wr_mapped = wr_prio4 || wr_icon2 || (aw_addr_r == vic_pkg::OFF_STAT);
   wire rd_mapped = (s_axi_araddr == vic_pkg::OFF_PRIO4) || (s_axi_araddr == vic_pkg::OFF_ICON2) ||
                    (s_axi_araddr == vic_pkg::OFF_STAT);
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire alt_sel = icon2_r[vic_pkg::ALT_BIT];
   wire busy = st_r != vic_pkg::ST_IDLE;
   wire [31:0] stat_word = {12'h000, act_lvl_r, 1'b0, act_idx_r, 6'h00, busy, core_irq};
   wire [31:0] rd_word = (s_axi_araddr == vic_pkg::OFF_PRIO4) ? {16'h0000, prio4_r} :
                         (s_axi_araddr == vic_pkg::OFF_ICON2) ? {16'h0000, icon2_r} :
                         (s_axi_araddr == vic_pkg::OFF_STAT) ? stat_word : 32'h00000000;

   assign s_axi_awready = ce && !aw_ok_r && !s_axi_bvalid;
   assign s_axi_wready = ce && !w_ok_r && !s_axi_bvalid;
   assign s_axi_arready = ce && !s_axi_rvalid;

   // Per-vector requests and levels
   wire [vic_pkg::NVEC-1:0] req_all = {irq_req, trap_req};
   logic [vic_pkg::NVEC-1:0][vic_pkg::LVL_W-1:0] lvl;
   logic [vic_pkg::NVEC-1:0] req_en;
   genvar i;
   generate
      for (i = 0; i < vic_pkg::NVEC; i++)
      begin : g_lvl
         localparam int S = i - vic_pkg::NTRAP;
         if (i < vic_pkg::NTRAP)
         begin : g_trap
            assign lvl[i] = vic_pkg::TRAP_LVL;
         end
         else if (S == vic_pkg::SRC_CN)
         begin : g_cn
            assign lvl[i] = {1'b0, prio4_r[vic_pkg::CN_LSB +: 3]};
         end
         else if (S == vic_pkg::SRC_CMP)
         begin : g_cmp
            assign lvl[i] = {1'b0, prio4_r[vic_pkg::CMP_LSB +: 3]};
         end
         else if (S == vic_pkg::SRC_MI2C)
         begin : g_mi2c
            assign lvl[i] = {1'b0, prio4_r[vic_pkg::MI2C_LSB +: 3]};
         end
         else if (S == vic_pkg::SRC_SI2C)
         begin : g_si2c
            assign lvl[i] = {1'b0, prio4_r[vic_pkg::SI2C_LSB +: 3]};
         end
         else
         begin : g_def
            assign lvl[i] = {1'b0, vic_pkg::DEF_PRIO};
         end
         assign req_en[i] = req_all[i] && (lvl[i] != 4'h0);
      end
   endgenerate

   vic_pkg::vic_win_s win;
   vic_prio_arb u_arb (
      .req(req_en),
      .lvl(lvl),
      .win(win)
   );

   // Traps bypass the core priority compare
   wire win_trap = win.idx < 7'(vic_pkg::NTRAP);
   wire elig = win.valid && (win_trap || win.lvl > core_ipl);
   wire take_ack = core_irq && core_ack;
   wire fetch_start = (st_r == vic_pkg::ST_ENTER) && (cnt_r == 4'h0);
   wire enter_end = cnt_r == 4'(vic_pkg::ENTRY_CYC - 1);
   wire ret_end = cnt_r == 4'(vic_pkg::RET_CYC - 1);

   vic_vec_fetch u_fetch (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .start(fetch_start),
      .alt(alt_sel),
      .idx(act_idx_r),
      .vt_rd(vt_rd),
      .vt_addr(vt_addr),
      .vt_data(vt_data),
      .isr_addr(isr_addr)
   );

   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         vic_pkg::ST_IDLE:
            if (take_ack)
               st_nxt = vic_pkg::ST_ENTER;
         vic_pkg::ST_ENTER:
            if (enter_end)
               st_nxt = vic_pkg::ST_SVC;
         vic_pkg::ST_SVC:
            if (core_ret)
               st_nxt = vic_pkg::ST_RET;
         vic_pkg::ST_RET:
            if (ret_end)
               st_nxt = vic_pkg::ST_IDLE;
         default:
            st_nxt = vic_pkg::ST_IDLE;
      endcase
   end

   // Service sequencing and core request
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= vic_pkg::ST_IDLE;
         cnt_r <= 4'h0;
         core_irq <= 1'b0;
         core_vec_idx <= 7'h00;
         core_irq_lvl <= 4'h0;
         act_idx_r <= 7'h00;
         act_lvl_r <= 4'h0;
         isr_valid <= 1'b0;
         boot_pend_r <= 1'b1;
      end
      else if (ce)
      begin
         st_r <= st_nxt;
         cnt_r <= (st_nxt != st_r) ? 4'h0 : cnt_r + 4'h1;
         boot_pend_r <= 1'b0;
         core_irq <= (st_r == vic_pkg::ST_IDLE) && !take_ack && !boot_pend_r && elig;
         if ((st_r == vic_pkg::ST_IDLE) && !take_ack)
         begin
            core_vec_idx <= win.idx;
            core_irq_lvl <= win.lvl;
         end
         if (take_ack)
         begin
            act_idx_r <= core_vec_idx;
            act_lvl_r <= core_irq_lvl;
         end
         isr_valid <= (st_r == vic_pkg::ST_ENTER) && enter_end;
      end
   end

   assign boot_load = boot_pend_r;
   assign boot_addr = vic_pkg::RESET_PC;

   // AXI4-Lite write path
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ok_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_ok_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= vic_pkg::RESP_OKAY;
         prio4_r <= vic_pkg::PRIO4_RST;
         icon2_r <= vic_pkg::ICON2_RST;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ok_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_wr)
         begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? vic_pkg::RESP_OKAY : vic_pkg::RESP_SLVERR;
            if (wr_prio4)
            begin
               prio4_r <= vic_pkg::vic_merge16(prio4_r, w_data_r, w_strb_r, vic_pkg::PRIO4_MASK);
            end
            if (wr_icon2)
            begin
               icon2_r <= vic_pkg::vic_merge16(icon2_r, w_data_r, w_strb_r, vic_pkg::ICON2_MASK);
            end
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read path
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= vic_pkg::RESP_OKAY;
         rd_prio_r <= 1'b0;
      end
      else if (ce)
      begin
         if (ar_take)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? vic_pkg::RESP_OKAY : vic_pkg::RESP_SLVERR;
            rd_prio_r <= s_axi_araddr == vic_pkg::OFF_PRIO4;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks
   logic [vic_pkg::NVEC-1:0] beats;
   generate
      for (i = 0; i < vic_pkg::NVEC; i++)
      begin : g_beat
         assign beats[i] = req_en[i] && (i != int'(win.idx)) &&
                           ((i < int'(win.idx)) ? (lvl[i] >= win.lvl) : (lvl[i] > win.lvl));
      end
   endgenerate

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn || !ce);

   chk_one_request: assert property (core_irq |-> st_r == vic_pkg::ST_IDLE)
      else $error("core request raised outside idle");
   chk_trap_unmasked: assert property ((st_r == vic_pkg::ST_IDLE) && !boot_pend_r && (|trap_req)
                                       && !take_ack |=> core_irq && core_vec_idx < 7'h08)
      else $error("trap request not presented");
   chk_level_range: assert property (core_irq && core_vec_idx >= 7'h08 |->
                                     core_irq_lvl <= 4'h7)
      else $error("interrupt level out of range");
   chk_fetch_addr: assert property (vt_rd |-> vt_addr ==
                                    vic_pkg::vic_vec_addr($past(alt_sel), act_idx_r))
      else $error("wrong vector table address");
   chk_fetch_data: assert property (vt_rd ##1 1'b1 |=> isr_addr == $past(vt_data))
      else $error("routine address not captured");
   chk_rank_order: assert property (win.valid |-> beats == '0)
      else $error("arbitration picked a losing vector");
   chk_enable_zero: assert property (core_irq |-> core_irq_lvl != 4'h0)
      else $error("disabled source requested");
   chk_above_core: assert property (core_irq && core_vec_idx >= 7'h08 |->
                                    core_irq_lvl > $past(core_ipl))
      else $error("request not above core priority");
   chk_entry_time: assert property (take_ack |-> !isr_valid [*5] ##1 isr_valid)
      else $error("entry latency wrong");
   chk_return_time: assert property ((st_r == vic_pkg::ST_SVC) && core_ret |->
                                     ##RET_D st_r == vic_pkg::ST_IDLE)
      else $error("return latency wrong");
   chk_prio_reserved: assert property (s_axi_rvalid && rd_prio_r |->
                                       (s_axi_rdata & 32'h00008888) == 32'h0)
      else $error("reserved priority bits nonzero");
   chk_boot_quiet: assert property (boot_load |=> !core_irq && !boot_load)
      else $error("request during reset bypass");

   cov_trap_served: cover property (take_ack && core_vec_idx < 7'h08 ##ENTRY_D isr_valid);
   cov_alt_table: cover property (vt_rd && alt_sel);
   cov_irq_return: cover property ((st_r == vic_pkg::ST_RET) ##1 (st_r == vic_pkg::ST_IDLE));
endmodule : vic_top

// ===== vic_core_model.sv
// Core model: acknowledges requests, serves the vector table word, returns
`timescale 1ns/1ps
module vic_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic core_irq,
   input wire logic [6:0] core_vec_idx,
   input wire logic [3:0] core_irq_lvl,
   input wire logic isr_valid,
   input wire logic [23:0] isr_addr,
   input wire logic vt_rd,
   input wire logic [23:0] vt_addr,
   input wire logic [3:0] ack_dly,
   output logic core_ack,
   output logic core_ret,
   output logic [23:0] vt_data,
   output logic [7:0] got_cnt,
   output logic [6:0] got_idx,
   output logic [3:0] got_lvl,
   output logic [23:0] got_va,
   output logic [23:0] got_isr,
   output logic [7:0] got_lat
);
   logic busy, svc, rd_q;
   logic [3:0] wt;
   logic [7:0] lat;
   logic [23:0] va_q, noise;
   // Table word valid in the strobe cycle and the next; a moving pattern otherwise
   assign vt_data = (vt_rd | rd_q) ? (24'ha00000 | (vt_rd ? vt_addr : va_q)) : noise;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         core_ack <= 1'b0;
         core_ret <= 1'b0;
         {busy, svc, rd_q, wt, lat, va_q} <= '0;
         {got_cnt, got_idx, got_lvl, got_va, got_isr, got_lat} <= '0;
         noise <= 24'h5a5a5a;
      end
      else
      begin
         noise <= noise + 24'h3c96a5;
         rd_q <= vt_rd;
         core_ack <= 1'b0;
         core_ret <= 1'b0;
         if (vt_rd)
         begin
            va_q <= vt_addr;
            got_va <= vt_addr;
         end
         if (lat != 8'h00)
         begin
            lat <= lat + 8'h01;
         end
         if (core_ack && core_irq)
         begin
            got_idx <= core_vec_idx;
            got_lvl <= core_irq_lvl;
            lat <= 8'h01;
            busy <= 1'b1;
         end
         else if (!busy && core_irq)
         begin
            // Slow acknowledge waits ack_dly cycles before answering
            wt <= (wt == ack_dly) ? 4'h0 : wt + 4'h1;
            core_ack <= (wt == ack_dly);
         end
         if (isr_valid && busy && !svc)
         begin
            got_isr <= isr_addr;
            got_lat <= lat;
            got_cnt <= got_cnt + 8'h01;
            lat <= 8'h00;
            svc <= 1'b1;
            wt <= 4'h0;
         end
         else if (svc)
         begin
            wt <= wt + 4'h1;
            if (wt == ack_dly)
            begin
               core_ret <= 1'b1;
               svc <= 1'b0;
               busy <= 1'b0;
               wt <= 4'h0;
            end
         end
      end
   end
endmodule : vic_core_model

// ===== tb.sv
// Testbench for the vectored interrupt controller
`timescale 1ns/1ps
module tb;
   logic aclk, aresetn, ce, core_ack, core_ret, core_irq, isr_valid, boot_load, vt_rd, saw_boot;
   logic [7:0] trap_req, got_cnt, got_lat;
   logic [117:0] irq_req;
   logic [3:0] core_ipl, core_irq_lvl, got_lvl, ack_dly;
   logic [6:0] core_vec_idx, got_idx;
   logic [23:0] isr_addr, boot_addr, vt_addr, vt_data, got_va, got_isr;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int miscompares, checks_done, p;

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   vic_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .trap_req(trap_req),
      .irq_req(irq_req), .core_ipl(core_ipl), .core_ack(core_ack), .core_ret(core_ret),
      .core_irq(core_irq), .core_vec_idx(core_vec_idx), .core_irq_lvl(core_irq_lvl),
      .isr_valid(isr_valid), .isr_addr(isr_addr), .boot_load(boot_load),
      .boot_addr(boot_addr), .vt_rd(vt_rd), .vt_addr(vt_addr), .vt_data(vt_data),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   vic_core_model core (.aclk(aclk), .aresetn(aresetn), .core_irq(core_irq),
      .core_vec_idx(core_vec_idx), .core_irq_lvl(core_irq_lvl), .isr_valid(isr_valid),
      .isr_addr(isr_addr), .vt_rd(vt_rd), .vt_addr(vt_addr), .ack_dly(ack_dly),
      .core_ack(core_ack), .core_ret(core_ret), .vt_data(vt_data), .got_cnt(got_cnt),
      .got_idx(got_idx), .got_lvl(got_lvl), .got_va(got_va), .got_isr(got_isr),
      .got_lat(got_lat));

   always @(posedge aclk)
   begin
      if (aresetn && boot_load === 1'b1)
         saw_boot <= 1'b1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task results;
      if (miscompares == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   // Handshakes are judged at the falling edge, where the next rising edge's view is settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] r;
      int n;
      {aw, w, b, n, r} = {3'b110, 32'd0, 2'h3};
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      while (!b && n < 100)
      begin
         @(negedge aclk);
         b = s_axi_bvalid;
         r = s_axi_bresp;
         aw = aw & !s_axi_awready;
         w = w & !s_axi_wready;
         @(posedge aclk);
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw, w, !b};
         n++;
      end
      chk(32'(r), 32'(er));
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ar, v;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      {ar, v, n, d, r} = {2'b10, 32'd0, 32'hffffffff, 2'h3};
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      while (!v && n < 100)
      begin
         @(negedge aclk);
         v = s_axi_rvalid;
         {d, r} = {s_axi_rdata, s_axi_rresp};
         ar = ar & !s_axi_arready;
         @(posedge aclk);
         {s_axi_arvalid, s_axi_rready} <= {ar, !v};
         n++;
      end
      chk(d, e);
      chk(32'(r), 32'(er));
   endtask : rd

   task automatic serve(input logic [117:0] irq, input logic [7:0] trp, input logic [3:0] ipl,
                        input logic [6:0] ei, input logic [3:0] el, input logic alt);
      logic [7:0] c0;
      logic [23:0] ea;
      int n;
      c0 = got_cnt;
      ea = (alt ? 24'h000100 : 24'h000004) + {16'h0000, ei, 1'b0};
      n = 0;
      @(posedge aclk);
      {irq_req, trap_req, core_ipl} <= {irq, trp, ipl};
      while (got_cnt == c0 && n < 300)
      begin
         @(negedge aclk);
         n++;
      end
      @(posedge aclk);
      {irq_req, trap_req} <= '0;
      chk(32'(got_cnt), 32'(c0 + 8'h01));
      chk(32'(got_idx), 32'(ei));
      chk(32'(got_lvl), 32'(el));
      chk(32'(got_va), 32'(ea));
      chk(32'(got_isr), 32'(24'ha00000 | ea));
      chk(32'(got_lat), 32'(vic_pkg::ENTRY_CYC + 1));
      repeat (20) @(posedge aclk);
   endtask : serve

   task automatic nosrv(input logic [117:0] irq, input logic [3:0] ipl);
      logic [7:0] c0;
      c0 = got_cnt;
      @(posedge aclk);
      {irq_req, core_ipl} <= {irq, ipl};
      repeat (20) @(posedge aclk);
      chk(32'(core_irq), 32'h0);
      chk(32'(got_cnt), 32'(c0));
      irq_req <= '0;
      repeat (3) @(posedge aclk);
   endtask : nosrv

   initial
   begin
      #300000;
      miscompares++;
      results;
   end

   initial
   begin
      {aresetn, trap_req, irq_req, core_ipl, ack_dly, saw_boot} = '0;
      ce = 1'b1;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(32'(saw_boot), 32'h1);
      chk(32'(boot_addr), 32'h0);
      rd(8'h00, 32'h4444, 2'h0);
      rd(8'h04, 32'h0, 2'h0);
      rd(8'h0c, 32'h0, 2'h2);
      wr(8'h0c, 32'hffffffff, 2'h2);
      wr(8'h00, 32'hffffffff, 2'h0);
      rd(8'h00, 32'h7777, 2'h0);
      wr(8'h00, 32'h0, 2'h0);
      serve(118'h1, 8'h28, 4'hf, 7'h03, 4'h8, 1'b0);
      wr(8'h08, 32'hffffffff, 2'h0);
      rd(8'h08, 32'h00080300, 2'h0);
      ce <= 1'b0;
      {irq_req, core_ipl} <= {118'h1, 4'h0};
      repeat (10) @(posedge aclk);
      chk(32'(core_irq), 32'h0);
      ce <= 1'b1;
      serve(118'h1, 8'h00, 4'h0, 7'd8, 4'h4, 1'b0);
      ack_dly <= 4'h5;
      for (p = 1; p < 8; p++)
      begin
         wr(8'h00, (p << 12) | ((p - 1) << 8), 2'h0);
         nosrv(118'hf << 16, 4'(p));
         serve(118'hf << 16, 8'h00, 4'(p - 1), 7'd26, 4'(p), 1'b0);
      end
      wr(8'h00, 32'h5550, 2'h0);
      serve(118'hf << 16, 8'h00, 4'h0, 7'd25, 4'h5, 1'b0);
      serve((118'h1 << 5) | 118'h1, 8'h00, 4'h3, 7'd8, 4'h4, 1'b0);
      serve(118'h1 << 117, 8'h00, 4'h0, 7'd125, 4'h4, 1'b0);
      wr(8'h00, 32'h0, 2'h0);
      nosrv(118'h1 << 16, 4'h0);
      ack_dly <= 4'h0;
      wr(8'h04, 32'hffff, 2'h0);
      rd(8'h04, 32'h8000, 2'h0);
      serve(118'h0, 8'h01, 4'hf, 7'd0, 4'h8, 1'b1);
      serve(118'h1 << 117, 8'h00, 4'h0, 7'd125, 4'h4, 1'b1);
      results;
   end
endmodule : tb
